// >>> rtl/ifp_core.sv
// fetch/execute sequencer of the 8-bit core
`include "ifp_consts.svh"

module ifp_core
    import ifp_pkg::*;
#(
    parameter int STACK_DEPTH = `IFP_STACK_DEPTH
)
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_sys_rst,
    output logic [`IFP_PC_W-1:0]       o_pm_addr,
    input  wire logic [15:0]           i_pm_word,
    output logic                       o_dm_rd,
    output logic                       o_dm_wr,
    output logic [11:0]                o_dm_addr,
    output logic [7:0]                 o_dm_wdata,
    input  wire logic [7:0]            i_dm_rdata,
    input  wire logic [3:0]            i_bank_sel,
    input  wire logic                  i_tp_load,
    input  wire logic [`IFP_TP_W-1:0]  i_tp_value,
    output logic [`IFP_PC_W-1:0]       o_program_counter,
    output logic [7:0]                 o_working_register,
    output logic [15:0]                o_instruction_holding_register,
    output logic                       o_ir_valid,
    output logic [`IFP_TP_W-1:0]       o_table_pointer,
    output logic [7:0]                 o_table_latch,
    output logic [`IFP_SP_W-1:0]       o_return_stack_pointer,
    output logic                       o_stack_full,
    output logic                       o_stack_underflow
);
    // ======================================================
    // decode helpers
    function automatic ifp_op_t dec_op(input logic [15:0] w);
        ifp_op_t r;
        r = OP_NOP;
        if (w[15:8] == `IFP_OPC_GOTO)
            r = OP_GOTO;
        else if (w[15:9] == `IFP_OPC_CALL)
            r = OP_CALL;
        else if (w[15:8] == `IFP_OPC_LFSR)
            r = OP_LFSR;
        else if (w[15:12] == `IFP_OPC_MOVE_PAIR)
            r = OP_MOVE_PAIR;
        else if (w[15:11] == `IFP_OPC_BRA)
            r = OP_BRA;
        else if (w[15:8] == `IFP_OPC_RET_LIT)
            r = OP_RET_LIT;
        else if (w[15:8] == `IFP_OPC_MOVLW)
            r = OP_MOVLW;
        else if (w[15:10] == `IFP_OPC_ADD_W)
            r = OP_ADD_W;
        else if (w[15:9] == `IFP_OPC_TEST_SKIP)
            r = OP_TEST_SKIP;
        else if (w[15:1] == `IFP_OPC_RETURN)
            r = OP_RETURN;
        else if (w[15:1] == `IFP_OPC_TBLRD)
            r = OP_TBLRD;
        return r;
    endfunction : dec_op

    // access bit clear: low files in bank 0, high files in the top bank
    function automatic logic [11:0] acc_addr(input logic       a,
                                             input logic [7:0] f,
                                             input logic [3:0] bank);
        logic [3:0] b;
        b = bank;
        if (!a)
            b = (f < `IFP_ACCESS_SPLIT) ? `IFP_ACCESS_LO_BNK
                                        : `IFP_ACCESS_HI_BNK;
        return {b, f};
    endfunction : acc_addr

    // ======================================================
    // phase divider
    ifp_phase_if ph_if ();

    ifp_phase_gen u_phase_gen (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .ph        (ph_if.gen)
    );

    // ======================================================
    // state
    logic [`IFP_PC_W-1:0] pc_ff,    nxt_pc;
    logic [`IFP_PC_W-1:0] fa_ff,    nxt_fa;
    logic [15:0]          fetch_ff, nxt_fetch;
    logic                 fval_ff,  nxt_fval;
    logic [15:0]          ir_ff,    nxt_ir;
    logic                 irv_ff,   nxt_irv;
    logic                 pair_ff,  nxt_pair;
    logic                 irp_ff,   nxt_irp;
    logic [7:0]           w_ff,     nxt_w;
    logic [7:0]           opnd_ff,  nxt_opnd;
    logic [7:0]           res_ff,   nxt_res;
    logic [11:0]          dma_ff,   nxt_dma;
    logic [`IFP_TP_W-1:0] tp_ff,    nxt_tp;
    logic [7:0]           tlat_ff,  nxt_tlat;
    logic                 tbl_ff,   nxt_tbl;
    logic                 tinc_ff,  nxt_tinc;
    logic [`IFP_SP_W-1:0] sp_ff,    nxt_sp;
    logic                 full_ff,  nxt_full;
    logic                 unf_ff,   nxt_unf;
    logic [`IFP_PC_W-1:0] stk_ff    [1:STACK_DEPTH];
    logic [`IFP_PC_W-1:0] nxt_stk   [1:STACK_DEPTH];

    ifp_op_t              op;
    logic                 clb;
    logic                 dst_file;
    logic [`IFP_PC_W-1:0] abs_tgt;
    logic [`IFP_PC_W-1:0] rel_tgt;
    logic [`IFP_SP_W-1:0] sp_inc;

    // ======================================================
    // execute-side decode of the held word
    always_comb
    begin
        op       = dec_op(ir_ff);
        clb      = !ir_ff[8] && (ir_ff[7:0] == `IFP_CLB_FILE);
        dst_file = ir_ff[9];
        // second word arrives on the bus in the same phase four
        abs_tgt  = {i_pm_word[11:0], ir_ff[7:0], 1'b0};
        rel_tgt  = fa_ff + {{9{ir_ff[10]}}, ir_ff[10:0], 1'b0};
        sp_inc   = sp_ff + `IFP_SP_W'(1);
    end

    // ======================================================
    // next-state
    always_comb
    begin
        nxt_pc    = pc_ff;
        nxt_fa    = fa_ff;
        nxt_fetch = fetch_ff;
        nxt_fval  = fval_ff;
        nxt_ir    = ir_ff;
        nxt_irv   = irv_ff;
        nxt_pair  = pair_ff;
        nxt_irp   = irp_ff;
        nxt_w     = w_ff;
        nxt_opnd  = opnd_ff;
        nxt_res   = res_ff;
        nxt_dma   = dma_ff;
        nxt_tp    = tp_ff;
        nxt_tlat  = tlat_ff;
        nxt_tbl   = tbl_ff;
        nxt_tinc  = tinc_ff;
        nxt_sp    = sp_ff;
        nxt_full  = full_ff;
        nxt_unf   = unf_ff;
        nxt_stk   = stk_ff;

        if (ph_if.q1)
        begin
            if (tbl_ff)
            begin
                // borrowed cycle: bus reads the word holding the byte
                nxt_fa  = {tp_ff[`IFP_PC_W-1:1], 1'b0};
                nxt_irv = 1'b0;
            end
            else
            begin
                nxt_fa   = pc_ff;
                nxt_pc   = pc_ff + `IFP_PC_STEP;
                nxt_ir   = fetch_ff;
                nxt_irv  = fval_ff;
                nxt_irp  = pair_ff;
                nxt_pair = 1'b0;
                if (pair_ff || dec_op(fetch_ff) == OP_MOVE_PAIR)
                    nxt_dma = fetch_ff[11:0];
                else
                    nxt_dma = acc_addr(fetch_ff[8], fetch_ff[7:0],
                                       i_bank_sel);
            end
        end

        if (o_dm_rd)
            nxt_opnd = i_dm_rdata;

        if (ph_if.q3)
        begin
            if (clb)
                nxt_res = fa_ff[7:0] + w_ff;
            else if (irp_ff)
                nxt_res = opnd_ff;
            else
                nxt_res = opnd_ff + w_ff;
        end

        if (ph_if.q4)
        begin
            if (tbl_ff)
            begin
                nxt_tlat = tp_ff[0] ? i_pm_word[15:8]
                                    : i_pm_word[7:0];
                if (tinc_ff)
                    nxt_tp = tp_ff + `IFP_TP_STEP;
                nxt_tbl = 1'b0;
            end
            else
            begin
                nxt_fetch = i_pm_word;
                nxt_fval  = 1'b1;
                if (irv_ff && !irp_ff)
                begin
                    unique case (op)
                        OP_MOVLW:
                            nxt_w = ir_ff[7:0];
                        OP_ADD_W:
                        begin
                            if (clb && dst_file)
                            begin
                                nxt_pc   = {fa_ff[`IFP_PC_W-1:8], res_ff};
                                nxt_fval = 1'b0;
                            end
                            else if (!dst_file)
                                nxt_w = res_ff;
                        end
                        OP_TEST_SKIP:
                            if (opnd_ff == 8'h00)
                                nxt_fval = 1'b0;
                        OP_BRA:
                        begin
                            nxt_pc   = rel_tgt;
                            nxt_fval = 1'b0;
                        end
                        OP_GOTO:
                        begin
                            nxt_pc   = abs_tgt;
                            nxt_fval = 1'b0;
                        end
                        OP_CALL:
                        begin
                            // a full stack keeps its last entry intact
                            if (sp_ff < STACK_DEPTH[`IFP_SP_W-1:0])
                            begin
                                nxt_sp          = sp_inc;
                                nxt_stk[sp_inc] = pc_ff;
                                if (sp_inc == STACK_DEPTH[`IFP_SP_W-1:0])
                                    nxt_full = 1'b1;
                            end
                            else
                                nxt_full = 1'b1;
                            nxt_pc   = abs_tgt;
                            nxt_fval = 1'b0;
                        end
                        OP_RETURN,
                        OP_RET_LIT:
                        begin
                            if (op == OP_RET_LIT)
                                nxt_w = ir_ff[7:0];
                            if (sp_ff == `IFP_SP_RST)
                            begin
                                nxt_pc  = `IFP_PC_RST;
                                nxt_unf = 1'b1;
                            end
                            else
                            begin
                                nxt_pc = stk_ff[sp_ff];
                                nxt_sp = sp_ff - `IFP_SP_W'(1);
                            end
                            nxt_fval = 1'b0;
                        end
                        OP_MOVE_PAIR:
                            nxt_pair = 1'b1;
                        OP_TBLRD:
                        begin
                            nxt_tbl  = 1'b1;
                            nxt_tinc = ir_ff[0];
                        end
                        OP_NOP,
                        OP_LFSR:
                            nxt_pair = 1'b0;
                    endcase
                end
            end
        end

        if (i_tp_load)
            nxt_tp = i_tp_value;
    end

    // ======================================================
    // registers
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            pc_ff    <= `IFP_PC_RST;
            fa_ff    <= `IFP_PC_RST;
            fetch_ff <= 16'h0000;
            fval_ff  <= 1'b0;
            ir_ff    <= 16'h0000;
            irv_ff   <= 1'b0;
            pair_ff  <= 1'b0;
            irp_ff   <= 1'b0;
            w_ff     <= 8'h00;
            opnd_ff  <= 8'h00;
            res_ff   <= 8'h00;
            dma_ff   <= 12'h000;
            tp_ff    <= 22'h000000;
            tlat_ff  <= 8'h00;
            tbl_ff   <= 1'b0;
            tinc_ff  <= 1'b0;
            sp_ff    <= `IFP_SP_RST;
            full_ff  <= 1'b0;
            unf_ff   <= 1'b0;
            for (int i = 1; i <= STACK_DEPTH; i++)
                stk_ff[i] <= `IFP_PC_RST;
        end
        else
        begin
            pc_ff    <= nxt_pc;
            fa_ff    <= nxt_fa;
            fetch_ff <= nxt_fetch;
            fval_ff  <= nxt_fval;
            ir_ff    <= nxt_ir;
            irv_ff   <= nxt_irv;
            pair_ff  <= nxt_pair;
            irp_ff   <= nxt_irp;
            w_ff     <= nxt_w;
            opnd_ff  <= nxt_opnd;
            res_ff   <= nxt_res;
            dma_ff   <= nxt_dma;
            tp_ff    <= nxt_tp;
            tlat_ff  <= nxt_tlat;
            tbl_ff   <= nxt_tbl;
            tinc_ff  <= nxt_tinc;
            sp_ff    <= nxt_sp;
            full_ff  <= nxt_full;
            unf_ff   <= nxt_unf;
            stk_ff   <= nxt_stk;
        end
    end

    // ======================================================
    // data memory strobes and outputs
    // counter low byte lives here for add, but a test-skip of it still reads the data bus
    assign o_dm_rd = ph_if.q2 && irv_ff && !irp_ff
                     && ((op == OP_ADD_W && !clb) || op == OP_TEST_SKIP
                         || op == OP_MOVE_PAIR);
    assign o_dm_wr = ph_if.q4 && irv_ff && !tbl_ff
                     && (irp_ff
                         || (op == OP_ADD_W && dst_file && !clb));

    assign o_pm_addr                      = fa_ff;
    assign o_dm_addr                      = dma_ff;
    assign o_dm_wdata                     = res_ff;
    assign o_program_counter              = pc_ff;
    assign o_working_register             = w_ff;
    assign o_instruction_holding_register = ir_ff;
    assign o_ir_valid                     = irv_ff;
    assign o_table_pointer                = tp_ff;
    assign o_table_latch                  = tlat_ff;
    assign o_return_stack_pointer         = sp_ff;
    assign o_stack_full                   = full_ff;
    assign o_stack_underflow              = unf_ff;
endmodule : ifp_core

// >>> rtl/ifp_consts.svh
// constants for the instruction fetch pipeline
// Function
// - clock divided by four into four non-overlapping phases per cycle.
// - counter advances in phase one; fetched word latched in phase four.
// - word latched in one cycle is executed during the next cycle.
// - fetch overlaps execute, one plain instruction per cycle.
// - flow changes take two cycles; prefetched word is discarded.
// - operand read in phase two, destination written in phase four.
// - program memory byte addressed, word low byte at even address.
// - counter steps by two; its lowest bit reads zero except after adding an odd working register to its low byte.
// - absolute jump and call load a word address into bits 20..1.
// - relative branch displacement in bytes is twice the offset.
// - two-word instructions carry 1111 prefix and 12 literal bits.
// - lone 1111-prefixed word is a no-op; in sequence supplies operand.
// - adding working register to counter low byte jumps that many bytes.
// - return with literal loads working register and pops the stack.
// - table pointer addresses a byte; table latch holds one moved byte.
// - both bytes of a program word are reachable by table access.
// - call increments stack pointer, then stores advanced counter.
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH

`define IFP_PC_W          21
`define IFP_TP_W          22
`define IFP_SP_W          5
`define IFP_STACK_DEPTH   31
`define IFP_PC_RST        21'h000000
`define IFP_PC_STEP       21'h000002
`define IFP_SP_RST        5'h00
`define IFP_TP_STEP       22'h000001
`define IFP_PAIR_PFX      4'hF
`define IFP_ACCESS_SPLIT  8'h60
`define IFP_ACCESS_HI_BNK 4'hF
`define IFP_ACCESS_LO_BNK 4'h0
`define IFP_CLB_FILE      8'hF9
`define IFP_OPC_GOTO      8'hEF
`define IFP_OPC_CALL      7'h76
`define IFP_OPC_LFSR      8'hEE
`define IFP_OPC_MOVE_PAIR 4'hC
`define IFP_OPC_BRA       5'h1A
`define IFP_OPC_RET_LIT   8'h0C
`define IFP_OPC_MOVLW     8'h0E
`define IFP_OPC_ADD_W     6'h09
`define IFP_OPC_TEST_SKIP 7'h33
`define IFP_OPC_RETURN    15'h0009
`define IFP_OPC_TBLRD     15'h0004

`endif

// >>> rtl/ifp_pkg.sv
// types shared by the instruction fetch pipeline
package ifp_pkg;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} ifp_phase_t;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_MOVLW,
        OP_ADD_W,
        OP_TEST_SKIP,
        OP_BRA,
        OP_GOTO,
        OP_CALL,
        OP_RETURN,
        OP_RET_LIT,
        OP_MOVE_PAIR,
        OP_LFSR,
        OP_TBLRD
    } ifp_op_t;

endpackage : ifp_pkg

// >>> rtl/ifp_phase_if.sv
// phase enables passed from the divider to the core
interface ifp_phase_if;
    import ifp_pkg::*;
    logic q1;
    logic q2;
    logic q3;
    logic q4;

    modport gen  (output q1, output q2, output q3, output q4);
    modport core (input q1, input q2, input q3, input q4);
endinterface : ifp_phase_if

// >>> rtl/ifp_phase_gen.sv
// divide-by-four phase enable generator
module ifp_phase_gen
    import ifp_pkg::*;
(
    input  wire logic   i_sys_clk,
    input  wire logic   i_sys_rst,
    ifp_phase_if.gen    ph
);
    ifp_phase_t ph_ff;
    ifp_phase_t nxt_ph;

    always_comb
    begin
        unique case (ph_ff)
            PH_Q1: nxt_ph = PH_Q2;
            PH_Q2: nxt_ph = PH_Q3;
            PH_Q3: nxt_ph = PH_Q4;
            PH_Q4: nxt_ph = PH_Q1;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ph_ff <= PH_Q1;
        else
            ph_ff <= nxt_ph;
    end

    // one-hot, so no two phases are ever active together
    assign ph.q1 = (ph_ff == PH_Q1);
    assign ph.q2 = (ph_ff == PH_Q2);
    assign ph.q3 = (ph_ff == PH_Q3);
    assign ph.q4 = (ph_ff == PH_Q4);
endmodule : ifp_phase_gen

// >>> bench/ifp_mem_model.sv
// program and data memory model facing the fetch core
module ifp_mem_model
(
    input  wire logic        i_sys_clk,
    input  wire logic [20:0] i_pm_addr,
    output logic      [15:0] o_pm_word,
    input  wire logic        i_dm_rd,
    input  wire logic        i_dm_wr,
    input  wire logic [11:0] i_dm_addr,
    input  wire logic [7:0]  i_dm_wdata,
    output logic      [7:0]  o_dm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [128];
    logic [7:0]  dm_val;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    int          rd_cnt;
    int          wr_cnt;

    // ==========================================
    // memory answers
    assign o_pm_word = mem[i_pm_addr[7:1]];
    assign dm_val = i_dm_addr[7:0] ^ {4'h0, i_dm_addr[11:8]};
    // inverted outside a read so a stale sample cannot pass
    assign o_dm_rdata = i_dm_rd ? dm_val : ~dm_val;

    always @(posedge i_sys_clk)
    begin
        if (i_dm_rd)
            rd_cnt++;
        if (i_dm_wr)
        begin
            wr_cnt++;
            wr_addr = i_dm_addr;
            wr_data = i_dm_wdata;
        end
    end
endmodule : ifp_mem_model

// >>> bench/ifp_core_monitor.sv
// assertion checker for the fetch pipeline core
`include "ifp_consts.svh"
module ifp_core_monitor
#(
    parameter int STACK_DEPTH = `IFP_STACK_DEPTH
)
(
    input wire logic                 i_sys_clk,
    input wire logic                 i_sys_rst,
    input wire logic [`IFP_PC_W-1:0] o_pm_addr,
    input wire logic                 o_dm_rd,
    input wire logic                 o_dm_wr,
    input wire logic                 i_tp_load,
    input wire logic [`IFP_PC_W-1:0] o_program_counter,
    input wire logic [15:0]          o_instruction_holding_register,
    input wire logic                 o_ir_valid,
    input wire logic [`IFP_TP_W-1:0] o_table_pointer,
    input wire logic [`IFP_SP_W-1:0] o_return_stack_pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_ff;
    logic [1:0] nxt_ph;

    // ==========================================
    // phase tracker: 1 means the fetch edge just passed
    always_comb nxt_ph = ph_ff + 2'h1;
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ph_ff <= 2'h0;
        else
            ph_ff <= nxt_ph;
    end

    // ==========================================
    // properties
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    chk_addr_even: assert property (
        !o_pm_addr[0] && !o_program_counter[0])
        else $error("odd program address");
    chk_fetch_phase: assert property (
        $changed(o_pm_addr) |-> ph_ff == 2'h1)
        else $error("fetch address moved off phase one");
    chk_ir_phase: assert property (
        $changed(o_instruction_holding_register) |-> ph_ff == 2'h1)
        else $error("held word moved off phase one");
    chk_valid_phase: assert property (
        $changed(o_ir_valid) |-> ph_ff == 2'h1)
        else $error("execute flag moved off phase one");
    chk_reset_idle: assert property (
        $fell(i_sys_rst) |-> !o_ir_valid [*5])
        else $error("execution in first cycle after reset");
    chk_rd_spacing: assert property (
        o_dm_rd |=> !o_dm_rd [*3])
        else $error("two operand reads in one cycle");
    chk_wr_after_rd: assert property (
        o_dm_wr |-> $past(o_dm_rd, 2) || $past(o_dm_rd, 6))
        else $error("write not in phase four after read");
    chk_sp_step: assert property (
        $changed(o_return_stack_pointer) |->
        o_return_stack_pointer == $past(o_return_stack_pointer) + 5'h01 ||
        o_return_stack_pointer + 5'h01 == $past(o_return_stack_pointer))
        else $error("stack pointer jumped");
    chk_sp_bound: assert property (
        o_return_stack_pointer <= STACK_DEPTH)
        else $error("stack pointer beyond depth");
    chk_tp_step: assert property (
        $changed(o_table_pointer) && !$past(i_tp_load) |->
        o_table_pointer == $past(o_table_pointer) + 22'h000001)
        else $error("table pointer moved by more than one");

    cover property (o_dm_wr);
    cover property (o_return_stack_pointer == 5'h01);
    cover property (o_ir_valid && !$stable(o_table_pointer));
endmodule : ifp_core_monitor

bind ifp_core ifp_core_monitor #(.STACK_DEPTH(STACK_DEPTH)) ifp_mon_inst (
    .i_sys_clk, .i_sys_rst, .o_pm_addr, .o_dm_rd, .o_dm_wr, .i_tp_load,
    .o_program_counter, .o_instruction_holding_register, .o_ir_valid,
    .o_table_pointer, .o_return_stack_pointer
);

// >>> bench/ifp_core_tb.sv
// self-checking bench for the fetch pipeline core
`include "ifp_consts.svh"
module ifp_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 i_sys_clk, i_sys_rst, i_tp_load;
    logic                 o_dm_rd, o_dm_wr, o_ir_valid;
    logic                 o_stack_full, o_stack_underflow;
    logic [`IFP_PC_W-1:0] o_pm_addr, o_program_counter;
    logic [`IFP_TP_W-1:0] i_tp_value, o_table_pointer;
    logic [15:0]          i_pm_word, o_instruction_holding_register;
    logic [11:0]          o_dm_addr;
    logic [7:0]           o_dm_wdata, i_dm_rdata, o_working_register;
    logic [7:0]           o_table_latch;
    logic [`IFP_SP_W-1:0] o_return_stack_pointer;
    logic [3:0]           i_bank_sel;
    int                   num_errors, samples_checked;
    logic [15:0]          img [28] = '{16'h0E04, 16'hEF08, 16'hF000,
        16'h0EAA, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hD001,
        16'h0E77, 16'hEC18, 16'hF000, 16'h6600, 16'hC123, 16'hF456,
        16'h0009, 16'hC123, 16'hF456, 16'hEF12, 16'hF000, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h26F9, 16'h0C01, 16'h0C02,
        16'h0C03};

    ifp_core ifp_core_inst (
        .i_sys_clk, .i_sys_rst, .o_pm_addr, .i_pm_word, .o_dm_rd,
        .o_dm_wr, .o_dm_addr, .o_dm_wdata, .i_dm_rdata, .i_bank_sel,
        .i_tp_load, .i_tp_value, .o_program_counter, .o_working_register,
        .o_instruction_holding_register, .o_ir_valid, .o_table_pointer,
        .o_table_latch, .o_return_stack_pointer, .o_stack_full,
        .o_stack_underflow
    );
    ifp_mem_model ifp_mem_model_inst (
        .i_sys_clk, .i_pm_addr(o_pm_addr), .o_pm_word(i_pm_word),
        .i_dm_rd(o_dm_rd), .i_dm_wr(o_dm_wr), .i_dm_addr(o_dm_addr),
        .i_dm_wdata(o_dm_wdata), .o_dm_rdata(i_dm_rdata)
    );

    // ==========================================
    // helpers
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic go(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : go

    // judge one instruction cycle just after its first edge
    task automatic step(input logic [20:0] pm, input logic v,
                        input logic [15:0] ir, input logic full);
        cmp(32'(o_pm_addr), 32'(pm));
        if (full)
        begin
            cmp(32'(o_program_counter), 32'(pm) + 32'h2);
            cmp(32'(o_ir_valid), 32'(v));
            if (v)
                cmp(32'(o_instruction_holding_register), 32'(ir));
        end
        go(4);
    endtask : step

    // ==========================================
    // scenarios
    task automatic t_reset();
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        i_tp_load <= 1'b1;
        i_tp_value <= 22'h3;
        go(1);
        i_tp_load <= 1'b0;
        step(21'h0, 1'b0, 16'h0, 1'b1);
        cmp(32'(o_working_register), 32'h0);
        cmp(32'(o_table_pointer), 32'h3);
        $display("test reset done");
    endtask : t_reset

    task automatic t_goto();
        step(21'h02, 1'b1, 16'h0E04, 1'b1);
        step(21'h04, 1'b1, 16'hEF08, 1'b1);
        step(21'h10, 1'b0, 16'h0, 1'b1);
        step(21'h12, 1'b1, 16'hD001, 1'b1);
        step(21'h14, 1'b0, 16'h0, 1'b1);
        $display("test jump done");
    endtask : t_goto

    task automatic t_call();
        step(21'h16, 1'b1, 16'hEC18, 1'b1);
        step(21'h30, 1'b0, 16'h0, 1'b1);
        cmp(32'(o_return_stack_pointer), 32'h1);
        step(21'h32, 1'b1, 16'h26F9, 1'b1);
        step(21'h36, 1'b0, 16'h0, 1'b1);
        step(21'h38, 1'b1, 16'h0C03, 1'b1);
        step(21'h18, 1'b0, 16'h0, 1'b1);
        cmp(32'(o_working_register), 32'h3);
        cmp(32'(o_return_stack_pointer), 32'h0);
        cmp(32'({o_stack_full, o_stack_underflow}), 32'h0);
        cmp(32'(ifp_mem_model_inst.rd_cnt), 32'h0);
        $display("test call done");
    endtask : t_call

    task automatic t_skip();
        step(21'h1A, 1'b1, 16'h6600, 1'b1);
        step(21'h1C, 1'b0, 16'h0, 1'b1);
        step(21'h1E, 1'b1, 16'hF456, 1'b1);
        cmp(32'(ifp_mem_model_inst.rd_cnt), 32'h1);
        $display("test skip done");
    endtask : t_skip

    task automatic t_table();
        step(21'h20, 1'b1, 16'h0009, 1'b1);
        step(21'h02, 1'b0, 16'h0, 1'b0);
        go(40);
        cmp(32'(o_table_latch), 32'hEF);
        cmp(32'(o_table_pointer), 32'h4);
        cmp(32'(ifp_mem_model_inst.wr_cnt), 32'h1);
        cmp(32'(ifp_mem_model_inst.wr_addr), 32'h456);
        cmp(32'(ifp_mem_model_inst.wr_data), 32'h22);
        cmp(32'(o_pm_addr[20:2]), 32'h9);
        $display("test table done");
    endtask : t_table

    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    // run takes about 130 clocks; a hang is cut well past that
    initial
    begin
        repeat (2000) @(posedge i_sys_clk);
        num_errors++;
        stop_test();
    end

    initial
    begin
        i_sys_rst = 1'b1;
        i_tp_load = 1'b0;
        i_tp_value = 22'h0;
        i_bank_sel = 4'h5;
        for (int i = 0; i < 128; i++)
            ifp_mem_model_inst.mem[i] = (i < 28) ? img[i] : 16'hFFFF;
        t_reset();
        t_goto();
        t_call();
        t_skip();
        t_table();
        t_reset();
        step(21'h02, 1'b1, 16'h0E04, 1'b1);
        stop_test();
    end
endmodule : ifp_core_tb
